/* File: hdl/mva_core.sv */
// Purpose: zone address legality check and mac verify command execution
// Assumes: inputs synchronous to mclk; hash core and key store outside
// Notes: key store answers slot_key_data in the same cycle as key_index_reg
//
// How it works
// - addresses count words; unused bits zero
// - offset low three bits, block above it
// - data slots 0-15; 4-byte only if public
// - config blocks 0-2; no reads above 16
// - config words above 10 word access only
// - config writes refused below 04, above 15
// - one-time blocks 0-1; writes only consumption
// - opcode 28 hashes, compares, returns 0/1
// - mode bit 0 picks challenge or scratch
// - mode bit 1 picks slot key or scratch
// - mode bit 2 must equal scratch flag when scratch used
// - bit 5 one-time bytes or zeros; reserved zero
// - only selector bits 3:0 pick slot
// - fixed order of hash message bytes
// - copy only mode 01 and read-key zero
// - target is selector+1 when even
// - copied scratch dropped on idle or sleep
// - wrong input size gives error, no execution
// - packet crc-16 checked before execution
`timescale 1ns/1ps
`include "mva_defines.svh"
module mva_core #(
	parameter int SLOTS = 16
) (
	input wire logic mclk,
	input wire logic reset,
	input wire mva_pkg::mva_addr_req_s addr_req,
	input wire logic [SLOTS-1:0] slot_secret_flag,
	input wire mva_pkg::mva_policy_e one_time_zone_policy,
	output logic addr_done_reg,
	output logic addr_legal_reg,
	output logic [3:0] addr_block_reg,
	output logic [2:0] addr_offset_reg,
	input wire mva_pkg::mva_mac_cmd_s mac_cmd,
	input wire logic [SLOTS*4-1:0] slot_read_key_field,
	input wire logic [71:0] serial_number_bytes,
	input wire logic [87:0] one_time_bytes,
	output logic [3:0] key_index_reg,
	input wire logic [255:0] slot_key_data,
	output logic hash_start_reg,
	output logic [703:0] hash_message_reg,
	input wire logic hash_done,
	input wire logic [255:0] hash_digest,
	input wire logic scratch_load,
	input wire logic [255:0] scratch_load_value,
	input wire logic scratch_load_flag,
	input wire logic idle_or_sleep,
	output logic busy_reg,
	output logic result_valid_reg,
	output logic [7:0] result_byte_reg,
	output logic [255:0] scratch_key_register_reg,
	output logic scratch_source_flag_reg,
	output logic scratch_valid_reg
);
	// block or slot field of an address; its width depends on the zone
	function automatic logic [3:0] zone_block(input mva_pkg::mva_addr_req_s r);
		logic [3:0] blk;
		case (r.zone)
			`MVA_ZONE_DATA: blk = r.second_parameter[6:3];
			`MVA_ZONE_CONFIG: blk = {2'b00, r.second_parameter[4:3]};
			default: blk = {3'b000, r.second_parameter[3]};
		endcase
		return blk;
	endfunction : zone_block

	// legality of one zone access; the checks are independent per zone
	function automatic logic addr_ok(input mva_pkg::mva_addr_req_s r, input logic [SLOTS-1:0] secret,
		input mva_pkg::mva_policy_e pol);
		logic [7:0] lo;
		logic [4:0] word;
		logic ok;
		lo = r.second_parameter[7:0];
		word = {lo[4:3], lo[2:0]};
		ok = (r.second_parameter[15:8] == 8'h00) && !lo[7];
		case (r.zone)
			`MVA_ZONE_DATA: begin
				if (!r.block32 && secret[zone_block(r)])
					ok = 1'b0;
			end
			`MVA_ZONE_CONFIG: begin
				if (lo[6:5] != 2'b00 || lo[4:3] > `MVA_CFG_LAST_BLOCK)
					ok = 1'b0;
				if (!r.is_write && word > `MVA_CFG_READ_MAX)
					ok = 1'b0;
				if (r.block32 && word > `MVA_CFG_BLOCK_MAX)
					ok = 1'b0;
				if (r.is_write && (word < `MVA_CFG_WRITE_MIN || word > `MVA_CFG_WRITE_MAX))
					ok = 1'b0;
			end
			`MVA_ZONE_OTP: begin
				if (lo[6:4] != 3'b000)
					ok = 1'b0;
				// legacy reads like read-only; its writes are refused
				if (r.is_write && pol != mva_pkg::MVA_POL_CONSUMPTION)
					ok = 1'b0;
			end
			default: ok = 1'b0;
		endcase
		return ok;
	endfunction : addr_ok

	logic addr_done_next;
	logic addr_legal_next;
	logic [3:0] addr_block_next;
	logic [2:0] addr_offset_next;

	// verdict and fields hold until the next request
	always_comb begin
		addr_done_next = addr_req.valid;
		addr_legal_next = addr_legal_reg;
		addr_block_next = addr_block_reg;
		addr_offset_next = addr_offset_reg;
		if (addr_req.valid) begin
			addr_legal_next = addr_ok(addr_req, slot_secret_flag, one_time_zone_policy);
			addr_offset_next = addr_req.second_parameter[2:0];
			addr_block_next = zone_block(addr_req);
		end
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			addr_done_reg <= 1'b0;
			addr_legal_reg <= 1'b0;
			addr_block_reg <= 4'h0;
			addr_offset_reg <= 3'h0;
		end else begin
			addr_done_reg <= addr_done_next;
			addr_legal_reg <= addr_legal_next;
			addr_block_reg <= addr_block_next;
			addr_offset_reg <= addr_offset_next;
		end
	end

	// scratch feeds the message when either source bit is set
	function automatic logic mode_uses_scratch(input logic [7:0] m);
		return m[`MVA_MODE_CHAL_BIT] | m[`MVA_MODE_KEY_BIT];
	endfunction : mode_uses_scratch

	// every refusal is decided before the key fetch, so no hash runs on bad input
	function automatic logic cmd_refused(input mva_pkg::mva_mac_cmd_s c, input logic flag, input logic valid);
		logic bad;
		bad = !c.crc_ok || c.data_len != `MVA_MAC_DATA_LEN;
		if ((c.first_parameter & `MVA_MODE_RSVD_MASK) != 8'h00)
			bad = 1'b1;
		if (mode_uses_scratch(c.first_parameter) && (c.first_parameter[`MVA_MODE_FLAG_BIT] != flag || !valid))
			bad = 1'b1;
		return bad;
	endfunction : cmd_refused

	mva_pkg::mva_state_e state_reg, state_next;
	mva_pkg::mva_mac_cmd_s cmd_reg, cmd_next;
	logic [3:0] key_index_next;
	logic hash_start_next;
	logic [703:0] hash_message_next;
	logic busy_next;
	logic result_valid_next;
	logic [7:0] result_byte_next;
	logic [255:0] scratch_next;
	logic scratch_flag_next;
	logic scratch_valid_next;
	logic copied_reg, copied_next;
	logic [7:0] mode;
	logic [3:0] target;
	logic [3:0] target_read_key;
	logic digest_match;

	assign mode = cmd_reg.first_parameter;
	assign digest_match = hash_digest == cmd_reg.client_response;
	// odd selector names the target itself, even one points one higher
	assign target = cmd_reg.slot_selector[0] ? cmd_reg.slot_selector[3:0]
		: cmd_reg.slot_selector[3:0] + 4'h1;
	assign target_read_key = slot_read_key_field[target*4 +: 4];

	always_comb begin
		state_next = state_reg;
		cmd_next = cmd_reg;
		key_index_next = key_index_reg;
		hash_start_next = 1'b0;
		hash_message_next = hash_message_reg;
		busy_next = busy_reg;
		result_valid_next = 1'b0;
		result_byte_next = result_byte_reg;
		scratch_next = scratch_key_register_reg;
		scratch_flag_next = scratch_source_flag_reg;
		scratch_valid_next = scratch_valid_reg;
		copied_next = copied_reg;
		// a copied key must not survive power-down states
		if (idle_or_sleep && copied_reg) begin
			scratch_next = 256'h0;
			scratch_valid_next = 1'b0;
			copied_next = 1'b0;
		end
		if (scratch_load) begin
			scratch_next = scratch_load_value;
			scratch_flag_next = scratch_load_flag;
			scratch_valid_next = 1'b1;
			copied_next = 1'b0;
		end
		case (state_reg)
			mva_pkg::MVA_IDLE: begin
				if (mac_cmd.valid && mac_cmd.opcode == `MVA_OP_MAC_VERIFY) begin
					cmd_next = mac_cmd;
					busy_next = 1'b1;
					key_index_next = mac_cmd.slot_selector[3:0];
					state_next = mva_pkg::MVA_KEY;
					// all checks come before any hashing
					if (cmd_refused(mac_cmd, scratch_source_flag_reg, scratch_valid_reg)) begin
						result_valid_next = 1'b1;
						result_byte_next = `MVA_STATUS_PARSE_ERR;
						busy_next = 1'b0;
						state_next = mva_pkg::MVA_IDLE;
					end
				end
			end
			mva_pkg::MVA_KEY: begin
				// slot key is valid in the same cycle that key_index_reg holds the selector
				hash_message_next = {
					mode[`MVA_MODE_KEY_BIT] ? scratch_key_register_reg : slot_key_data,
					mode[`MVA_MODE_CHAL_BIT] ? scratch_key_register_reg : cmd_reg.client_challenge,
					cmd_reg.mac_filler_bytes[103:72],
					mode[`MVA_MODE_OTP_BIT] ? one_time_bytes[87:24] : 64'h0000_0000_0000_0000,
					cmd_reg.mac_filler_bytes[71:48],
					serial_number_bytes[7:0],
					cmd_reg.mac_filler_bytes[47:16],
					serial_number_bytes[71:56],
					cmd_reg.mac_filler_bytes[15:0]
				};
				hash_start_next = 1'b1;
				state_next = mva_pkg::MVA_HASH;
			end
			mva_pkg::MVA_HASH: begin
				state_next = mva_pkg::MVA_WAIT;
			end
			mva_pkg::MVA_WAIT: begin
				if (hash_done) begin
					result_byte_next = digest_match ? `MVA_RESULT_MATCH : `MVA_RESULT_MISMATCH;
					// a failed compare or a barred copy leaves scratch untouched
					if (digest_match && mode == `MVA_COPY_MODE
						&& target_read_key == 4'h0) begin
						key_index_next = target;
						state_next = mva_pkg::MVA_COPY;
					end else begin
						result_valid_next = 1'b1;
						busy_next = 1'b0;
						state_next = mva_pkg::MVA_IDLE;
					end
				end
			end
			mva_pkg::MVA_COPY: begin
				// key_index_reg moved to the target last cycle, so the store shows it now
				scratch_next = slot_key_data;
				scratch_valid_next = 1'b1;
				copied_next = 1'b1;
				result_valid_next = 1'b1;
				busy_next = 1'b0;
				state_next = mva_pkg::MVA_IDLE;
			end
			default: begin
				busy_next = 1'b0;
				state_next = mva_pkg::MVA_IDLE;
			end
		endcase
	end

	always_ff @(posedge mclk or posedge reset) begin
		if (reset) begin
			state_reg <= mva_pkg::MVA_IDLE;
			cmd_reg <= '0;
			key_index_reg <= 4'h0;
			hash_start_reg <= 1'b0;
			hash_message_reg <= '0;
			busy_reg <= 1'b0;
			result_valid_reg <= 1'b0;
			result_byte_reg <= 8'h00;
			scratch_key_register_reg <= '0;
			scratch_source_flag_reg <= 1'b0;
			scratch_valid_reg <= 1'b0;
			copied_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cmd_reg <= cmd_next;
			key_index_reg <= key_index_next;
			hash_start_reg <= hash_start_next;
			hash_message_reg <= hash_message_next;
			busy_reg <= busy_next;
			result_valid_reg <= result_valid_next;
			result_byte_reg <= result_byte_next;
			scratch_key_register_reg <= scratch_next;
			scratch_source_flag_reg <= scratch_flag_next;
			scratch_valid_reg <= scratch_valid_next;
			copied_reg <= copied_next;
		end
	end
endmodule : mva_core

/* File: hdl/mva_defines.svh */
// Purpose: constants of the mac verify and address decode block
// Assumes: byte 0 of any multi-byte field sits in its top bits
// Notes: definitions only
`ifndef MVA_DEFINES_SVH
`define MVA_DEFINES_SVH
`define MVA_OP_MAC_VERIFY 8'h28
`define MVA_MAC_DATA_LEN 8'h4D
`define MVA_COPY_MODE 8'h01
`define MVA_MODE_RSVD_MASK 8'hD8
`define MVA_MODE_CHAL_BIT 0
`define MVA_MODE_KEY_BIT 1
`define MVA_MODE_FLAG_BIT 2
`define MVA_MODE_OTP_BIT 5
`define MVA_RESULT_MATCH 8'h00
`define MVA_RESULT_MISMATCH 8'h01
`define MVA_STATUS_PARSE_ERR 8'h03
`define MVA_ZONE_CONFIG 2'h0
`define MVA_ZONE_OTP 2'h1
`define MVA_ZONE_DATA 2'h2
`define MVA_CFG_LAST_BLOCK 2'h2
`define MVA_CFG_READ_MAX 5'h10
`define MVA_CFG_BLOCK_MAX 5'h0A
`define MVA_CFG_WRITE_MIN 5'h04
`define MVA_CFG_WRITE_MAX 5'h0F
`endif

/* File: hdl/mva_pkg.sv */
// Purpose: types of the mac verify and address decode block
// Assumes: nothing beyond the defines header
// Notes: carriers are packed, byte 0 highest
package mva_pkg;
	typedef enum logic [2:0] {
		MVA_IDLE = 3'b000,
		MVA_KEY = 3'b001,
		MVA_HASH = 3'b010,
		MVA_WAIT = 3'b011,
		MVA_COPY = 3'b100
	} mva_state_e;
	typedef enum logic [1:0] {
		MVA_POL_READ_ONLY = 2'b00,
		MVA_POL_CONSUMPTION = 2'b01,
		MVA_POL_LEGACY = 2'b10
	} mva_policy_e;
	typedef struct packed {
		logic valid;
		logic [1:0] zone;
		logic is_write;
		logic block32;
		logic [15:0] second_parameter;
	} mva_addr_req_s;
	typedef struct packed {
		logic valid;
		logic crc_ok;
		logic [7:0] opcode;
		logic [7:0] first_parameter;
		logic [15:0] slot_selector;
		logic [7:0] data_len;
		logic [255:0] client_challenge;
		logic [255:0] client_response;
		logic [103:0] mac_filler_bytes;
	} mva_mac_cmd_s;
endpackage : mva_pkg

/* File: verification/mva_core_sva.sv */
// Purpose: port checker of mva_core
// Assumes: reset async high, mclk rising edge
// Notes: config word is second_parameter[4:0]
`timescale 1ns/1ps
module mva_core_sva (
	input wire logic mclk,
	input wire logic reset,
	input wire mva_pkg::mva_addr_req_s addr_req,
	input wire mva_pkg::mva_policy_e one_time_zone_policy,
	input wire logic addr_done_reg,
	input wire logic addr_legal_reg,
	input wire mva_pkg::mva_mac_cmd_s mac_cmd,
	input wire logic [3:0] key_index_reg,
	input wire logic hash_start_reg,
	input wire logic hash_done,
	input wire logic busy_reg,
	input wire logic result_valid_reg,
	input wire logic [7:0] result_byte_reg
);
	default clocking @(posedge mclk); endclocking
	default disable iff (reset);
	logic [4:0] w;
	assign w = addr_req.second_parameter[4:0];
	sequence s_cfg;
		addr_req.valid && addr_req.zone == 2'h0;
	endsequence
	sequence s_acc;
		mac_cmd.valid && mac_cmd.opcode == 8'h28 && !busy_reg;
	endsequence
	AST_ADDR_DONE: assert property (addr_req.valid |=> addr_done_reg) else $error("no done");
	AST_ADDR_HIGH: assert property (addr_req.valid && addr_req.second_parameter[15:7] != 0 |=> !addr_legal_reg)
		else $error("high byte legal");
	AST_CFG_READ: assert property (s_cfg ##0 (!addr_req.is_write && w > 16) |=> !addr_legal_reg)
		else $error("cfg read legal");
	AST_CFG_WORD: assert property (s_cfg ##0 (w > 10 && addr_req.block32) |=> !addr_legal_reg)
		else $error("cfg block legal");
	AST_CFG_WRITE: assert property (s_cfg ##0 (addr_req.is_write && (w < 4 || w > 15)) |=> !addr_legal_reg)
		else $error("cfg write legal");
	AST_OTP_WRITE: assert property (addr_req.valid && addr_req.zone == 2'h1 && addr_req.is_write &&
		one_time_zone_policy != mva_pkg::MVA_POL_CONSUMPTION |=> !addr_legal_reg) else $error("otp write");
	AST_MAC_ERR: assert property (s_acc ##0 (!mac_cmd.crc_ok || mac_cmd.data_len != 8'h4D ||
		(mac_cmd.first_parameter & 8'hD8) != 0) |=> result_valid_reg && result_byte_reg == 8'h03)
		else $error("no error");
	AST_MAC_KEY: assert property (s_acc ##0 (mac_cmd.crc_ok && mac_cmd.data_len == 8'h4D &&
		mac_cmd.first_parameter == 8'h00) |=> key_index_reg == $past(mac_cmd.slot_selector[3:0]) ##1 hash_start_reg)
		else $error("key index");
	AST_MAC_RESULT: assert property (busy_reg && hash_done |-> ##[1:2] (result_valid_reg &&
		result_byte_reg[7:1] == 7'h0)) else $error("no result");
endmodule : mva_core_sva
bind mva_core mva_core_sva u_mva_core_sva (.*);

/* File: verification/mva_partner.sv */
// Purpose: hash core and key store beside mva_core
// Assumes: digest is a fold of the message
// Notes: digest shows inverted data outside done
`timescale 1ns/1ps
module mva_partner (
	input wire logic mclk,
	input wire logic [3:0] key_index_reg,
	output logic [255:0] slot_key_data,
	input wire logic hash_start_reg,
	input wire logic [703:0] hash_message_reg,
	input var int lat,
	output logic hash_done,
	output logic [255:0] hash_digest
);
	logic [255:0] d;
	assign slot_key_data = {32{4'hA, key_index_reg}};
	initial begin
		hash_done = 0;
		hash_digest = '0;
		forever begin
			@(posedge mclk);
			if (hash_start_reg) begin
				d = hash_message_reg[703:448] ^ hash_message_reg[447:192] ^ {hash_message_reg[191:0], 64'h0};
				repeat (lat) @(posedge mclk);
				hash_done <= 1;
				hash_digest <= d;
				@(posedge mclk);
				hash_done <= 0;
				hash_digest <= ~d;
			end
		end
	end
endmodule : mva_partner

/* File: verification/tb.sv */
// Purpose: self-checking bench of mva_core
// Assumes: partner hashes after lat cycles
// Notes: flag after a copy is not predicted
`timescale 1ns/1ps
module tb;
	logic mclk = 0, reset = 1, scratch_load = 0, scratch_load_flag = 0, idle_or_sleep = 0;
	mva_pkg::mva_addr_req_s addr_req = '0;
	mva_pkg::mva_mac_cmd_s mac_cmd = '0;
	mva_pkg::mva_policy_e one_time_zone_policy = mva_pkg::MVA_POL_READ_ONLY;
	logic [15:0] slot_secret_flag = '0;
	logic [63:0] slot_read_key_field = '0;
	logic [71:0] serial_number_bytes = '0;
	logic [87:0] one_time_bytes = '0;
	logic [255:0] scratch_load_value = '0, slot_key_data, hash_digest, scratch_key_register_reg, sk = '0;
	logic [703:0] hash_message_reg;
	logic [3:0] key_index_reg, addr_block_reg;
	logic [2:0] addr_offset_reg;
	logic [7:0] result_byte_reg;
	logic hash_start_reg, hash_done, addr_done_reg, addr_legal_reg, busy_reg, result_valid_reg;
	logic scratch_source_flag_reg, scratch_valid_reg, sv = 0, sf = 0, scp = 0;
	int errors = 0, samples_checked = 0, seed = 62888, lat = 1, i;
	always #5 mclk = ~mclk;
	mva_core u_mva_core (.*);
	mva_partner u_mva_partner (.*);
	function automatic logic [255:0] fold(input logic [703:0] m);
		fold = m[703:448] ^ m[447:192] ^ {m[191:0], 64'h0};
	endfunction : fold
	task automatic cmp(input logic [703:0] got, input logic [703:0] exp);
		samples_checked++;
		if (got !== exp) begin
			errors++;
			$display("unexpected at %0t: got %0h exp %0h", $time, got, exp);
		end
	endtask : cmp
	task automatic finish_test();
		$display("errors %0d samples_checked %0d", errors, samples_checked);
		if (errors == 0 && samples_checked > 0) $display("No errors found");
		else $display("Errors were found");
		$finish;
	endtask : finish_test
	task automatic addr_run();
		logic [7:0] b;
		logic ok;
		for (i = 0; i < 400; i++) begin
			b = $random(seed);
			addr_req.zone = $random(seed);
			addr_req.is_write = $random(seed);
			addr_req.block32 = $random(seed);
			one_time_zone_policy = mva_pkg::mva_policy_e'(i % 3);
			slot_secret_flag = $random(seed);
			if (addr_req.zone == 2'h0) b[6:5] = 2'h0;
			if (addr_req.zone == 2'h1) b[6:4] = 3'h0;
			if ($random(seed) % 8) b[7] = 0;
			addr_req.second_parameter = {(i % 29 == 0) ? 8'h01 : 8'h00, b};
			ok = addr_req.second_parameter[15:7] == 0;
			case (addr_req.zone)
				2'h0: ok &= (addr_req.is_write ? (b[4:0] >= 4 && b[4:0] <= 15) : b[4:0] <= 16) &&
					!(b[4:0] > 10 && addr_req.block32);
				2'h1: ok &= !addr_req.is_write || one_time_zone_policy == mva_pkg::MVA_POL_CONSUMPTION;
				2'h2: ok &= addr_req.block32 || !slot_secret_flag[b[6:3]];
				default: ok = 0;
			endcase
			@(negedge mclk);
			cmp(addr_done_reg, 1);
			cmp(addr_legal_reg, ok);
			if (ok) cmp({addr_block_reg, addr_offset_reg}, {addr_req.zone == 2'h2 ? b[6:3] :
				addr_req.zone == 2'h1 ? {3'h0, b[3]} : {2'h0, b[4:3]}, b[2:0]});
		end
	endtask : addr_run
	task automatic mac(input logic [7:0] md, input logic [3:0] sel, input logic hit, input logic crc,
		input logic [7:0] len);
		logic [255:0] ch;
		logic [103:0] f;
		logic [703:0] m;
		logic [11:0] hi;
		logic [3:0] t;
		logic err;
		int n, starts;
		ch = {8{$random(seed)}};
		f = {8'h08, 24'($random(seed)), one_time_bytes[23:0],
			serial_number_bytes[39:8], serial_number_bytes[55:40]};
		hi = $random(seed);
		lat = ($random(seed) & 15) + 1;
		m = {md[1] ? sk : {32{4'hA, sel}}, md[0] ? sk : ch, f[103:72], md[5] ? one_time_bytes[87:24] : 64'h0,
			f[71:48], serial_number_bytes[7:0], f[47:16], serial_number_bytes[71:56], f[15:0]};
		err = !crc || len != 8'h4D || (md & 8'hD8) != 0 || ((md[0] | md[1]) && (md[2] != sf || !sv));
		mac_cmd = '{1'b1, crc, 8'h28, md, {hi, sel}, len, ch, hit ? fold(m) : ~fold(m), f};
		@(negedge mclk);
		mac_cmd.valid = 0;
		starts = 0;
		for (n = 0; n < 100 && result_valid_reg !== 1; n++) begin
			cmp(busy_reg, 1);
			if (hash_start_reg === 1) begin
				starts++;
				cmp(hash_message_reg, m);
			end
			@(negedge mclk);
		end
		if (result_valid_reg !== 1) begin
			cmp(0, 1);
			finish_test();
		end
		cmp(result_byte_reg, err ? 8'h03 : (hit ? 8'h00 : 8'h01));
		cmp(starts, !err);
		cmp(busy_reg, 0);
		t = sel[0] ? sel : sel + 1;
		if (!err && hit && md == 8'h01 && slot_read_key_field[t*4 +: 4] == 0) begin
			sk = {32{4'hA, t}};
			sv = 1;
			scp = 1;
		end
		cmp({scratch_valid_reg, scratch_key_register_reg}, {sv, sk});
		@(negedge mclk);
	endtask : mac
	task automatic load(input logic fl);
		scratch_load = 1;
		scratch_load_flag = fl;
		scratch_load_value = {8{$random(seed)}};
		sk = scratch_load_value;
		{sv, sf, scp} = {1'b1, fl, 1'b0};
		@(negedge mclk);
		scratch_load = 0;
		@(negedge mclk);
		cmp({scratch_source_flag_reg, scratch_key_register_reg}, {fl, sk});
	endtask : load
	task automatic idle();
		idle_or_sleep = 1;
		@(negedge mclk);
		idle_or_sleep = 0;
		if (scp) begin
			sv = 0;
			scp = 0;
			sk = '0;
		end
		@(negedge mclk);
		cmp({scratch_valid_reg, scratch_key_register_reg}, {sv, sk});
	endtask : idle
	initial begin
		serial_number_bytes = {8'($random(seed)), $random(seed), $random(seed)};
		one_time_bytes = {24'($random(seed)), $random(seed), $random(seed)};
		slot_read_key_field = {$random(seed), $random(seed)};
		slot_read_key_field[23:20] = 4'h0;
		slot_read_key_field[31:28] = 4'h3;
		repeat (2) @(negedge mclk);
		reset = 0;
		addr_req.valid = 1;
		addr_run();
		addr_req.valid = 0;
		@(negedge mclk);
		load(0);
		mac(8'h00, 2, 1, 1, 8'h4D);
		mac(8'h00, 3, 0, 1, 8'h4D);
		mac(8'h20, 9, 1, 1, 8'h4D);
		mac(8'h02, 1, 1, 1, 8'h4D);
		mac(8'h01, 7, 1, 1, 8'h4D);
		mac(8'h01, 4, 1, 1, 8'h4D);
		idle();
		mac(8'h01, 4, 1, 1, 8'h4D);
		load(1);
		idle();
		mac(8'h05, 0, 1, 1, 8'h4D);
		mac(8'h01, 0, 1, 1, 8'h4D);
		mac(8'h00, 2, 1, 0, 8'h4D);
		mac(8'h00, 2, 1, 1, 8'h4C);
		mac(8'h08, 2, 1, 1, 8'h4D);
		mac(8'h40, 2, 1, 1, 8'h4D);
		finish_test();
	end
endmodule : tb
